//--- rtl/rfc_controller.sv
// rom flash bank controller top
`timescale 1ns/1ps
module rfc_controller #(
    parameter int NBANK = rfc_pkg::NBANK,
    parameter int AW = rfc_pkg::AW,
    parameter int DW = rfc_pkg::DW,
    parameter int WAITW = rfc_pkg::WAITW
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [DW-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic req_retry_o,
    output logic rsp_valid_o,
    output logic [DW-1:0] rsp_rdata_o,
    output logic sdram_access_allow_o,
    input wire logic retry_on_rom_read_enable_i,
    input wire logic [NBANK*AW-1:0] bank_base_i,
    input wire logic [NBANK*AW-1:0] bank_mask_i,
    input wire logic [NBANK*WAITW-1:0] first_wait_count_i,
    input wire logic [NBANK*WAITW-1:0] recovery_count_i,
    input wire logic [NBANK-1:0] bank_port_select_i,
    input wire logic [NBANK-1:0] bank_ready_use_i,
    input wire logic [1:0] addr_mux_mode_i,
    input wire logic bus_parity_enable_i,
    input wire logic parity_gpio_enable_i,
    input wire logic external_master_enable_i,
    input wire logic rom_device_ready_in_i,
    input wire logic [DW-1:0] sdram_data_i,
    input wire logic [7:0] rom_dedicated_data_port_i,
    output logic [DW-1:0] sdram_data_o,
    output logic sdram_data_oe_o,
    output logic [7:0] rom_dedicated_data_port_o,
    output logic rom_dedicated_data_port_oe_o,
    output logic [rfc_pkg::SDA_W-1:0] sdram_address_pins_o,
    output logic [5:0] proc_bus_parity_pins_o,
    output logic proc_bus_parity_pins_oe_o,
    output logic [5:0] arbiter_pins_o,
    output logic arbiter_pins_oe_o,
    output logic [NBANK-1:0] rom_bank_select_n_o,
    output logic rom_output_enable_n_o,
    output logic rom_write_enable_n_o,
    output logic rom_read_not_write_o,
    output logic rom_transceiver_select_n_o,
    output logic sdram_side_buffer_select_o
);
    // ------------------------------------------------
    // request capture and bank decode
    // ------------------------------------------------
    rfc_pkg::rfc_state_e state;
    logic [AW-1:0] addr;
    logic write;
    logic [DW-1:0] wbuf;
    logic [DW-1:0] rbuf;
    logic [NBANK-1:0] hit;
    logic [NBANK-1:0] cur_bank;
    logic [WAITW-1:0] cnt;
    logic [WAITW-1:0] cur_fw;
    logic [WAITW-1:0] cur_rec;
    logic cur_port;
    logic cur_rdy;
    logic [1:0] phase;
    logic read_done;
    logic any_hit;

    genvar gb;
    generate
        for (gb = 0; gb < NBANK; gb++)
        begin : g_dec
            assign hit[gb] = ((req_addr_i ^ bank_base_i[gb*AW +: AW])
                & bank_mask_i[gb*AW +: AW]) == '0;
        end
    endgenerate

    // lowest-numbered bank wins if ranges overlap
    logic [NBANK-1:0] pick;
    assign pick = hit & (~hit + 1'b1);
    assign any_hit = |hit;

    always_comb
    begin
        cur_fw = '0;
        cur_rec = '0;
        cur_port = 1'b0;
        cur_rdy = 1'b0;
        for (int i = 0; i < NBANK; i++)
        begin
            if (cur_bank[i])
            begin
                cur_fw = first_wait_count_i[i*WAITW +: WAITW];
                cur_rec = recovery_count_i[i*WAITW +: WAITW];
                cur_port = bank_port_select_i[i];
                cur_rdy = bank_ready_use_i[i];
            end
        end
    end

    // ------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------
    logic idle;
    logic busy_read;
    logic data_ok;
    logic mux_extra;
    assign idle = state == rfc_pkg::RFC_IDLE;
    assign busy_read = !idle && !write;
    assign data_ok = (cnt == '0) && (!cur_rdy || rom_device_ready_in_i);
    // byte port address phases only when it is also the data port
    assign mux_extra = !cur_port && (addr_mux_mode_i == rfc_pkg::MUX_FULL);

    // writes posted, reads accepted but answered later
    assign req_ready_o = req_valid_i && any_hit && idle;
    assign req_retry_o = req_valid_i && any_hit && !idle && busy_read
        && retry_on_rom_read_enable_i;
    assign sdram_access_allow_o = !(busy_read && !retry_on_rom_read_enable_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state <= rfc_pkg::RFC_IDLE;
            cnt <= '0;
            phase <= '0;
        end
        else
        begin
            case (state)
                rfc_pkg::RFC_IDLE:
                begin
                    if (req_ready_o)
                    begin
                        state <= rfc_pkg::RFC_ADDR;
                        phase <= '0;
                    end
                end
                rfc_pkg::RFC_ADDR:
                begin
                    if (!mux_extra
                        || phase == 2'(rfc_pkg::ADDR_PHASES - 1))
                    begin
                        state <= rfc_pkg::RFC_WAIT;
                        cnt <= cur_fw;
                    end
                    else
                    begin
                        phase <= phase + 2'h1;
                    end
                end
                rfc_pkg::RFC_WAIT:
                begin
                    if (cnt != '0)
                    begin
                        cnt <= cnt - 1'b1;
                    end
                    else if (data_ok)
                    begin
                        state <= rfc_pkg::RFC_DONE;
                    end
                end
                rfc_pkg::RFC_DONE:
                begin
                    state <= rfc_pkg::RFC_RECV;
                    cnt <= cur_rec;
                end
                rfc_pkg::RFC_RECV:
                begin
                    if (cnt != '0)
                    begin
                        cnt <= cnt - 1'b1;
                    end
                    else
                    begin
                        state <= write ? rfc_pkg::RFC_IDLE
                            : rfc_pkg::RFC_RESP;
                    end
                end
                rfc_pkg::RFC_RESP:
                begin
                    state <= rfc_pkg::RFC_IDLE;
                end
                default:
                begin
                    state <= rfc_pkg::RFC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            addr <= '0;
            write <= 1'b0;
            wbuf <= '0;
            cur_bank <= '0;
        end
        else if (req_ready_o)
        begin
            addr <= req_addr_i;
            write <= req_write_i;
            wbuf <= req_wdata_i;
            cur_bank <= pick;
        end
    end

    // data gathered at capture, returned only afterwards
    assign read_done = (state == rfc_pkg::RFC_WAIT) && data_ok && !write;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rbuf <= '0;
        end
        else if (read_done)
        begin
            rbuf <= cur_port ? sdram_data_i
                : {{(DW-8){1'b0}}, rom_dedicated_data_port_i};
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end
        else
        begin
            rsp_valid_o <= (state == rfc_pkg::RFC_RECV) && (cnt == '0)
                && !write;
            rsp_rdata_o <= rbuf;
        end
    end

    // ------------------------------------------------
    // memory pins
    // ------------------------------------------------
    logic active;
    logic strobe;
    assign active = (state == rfc_pkg::RFC_ADDR)
        || (state == rfc_pkg::RFC_WAIT) || (state == rfc_pkg::RFC_DONE);
    assign strobe = state == rfc_pkg::RFC_WAIT;

    // registered pins; settle one cycle after the state changes
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rom_bank_select_n_o <= '1;
            rom_output_enable_n_o <= 1'b1;
            rom_write_enable_n_o <= 1'b1;
            rom_read_not_write_o <= 1'b0;
            rom_transceiver_select_n_o <= 1'b1;
            sdram_side_buffer_select_o <= 1'b0;
        end
        else
        begin
            rom_bank_select_n_o <= strobe ? ~cur_bank : '1;
            rom_output_enable_n_o <= !(strobe && !write);
            rom_write_enable_n_o <= !(strobe && write);
            rom_read_not_write_o <= active && !write;
            rom_transceiver_select_n_o <= !active;
            sdram_side_buffer_select_o <= active && cur_port;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sdram_address_pins_o <= '0;
            rom_dedicated_data_port_o <= '0;
            rom_dedicated_data_port_oe_o <= 1'b0;
            sdram_data_o <= '0;
            sdram_data_oe_o <= 1'b0;
            proc_bus_parity_pins_o <= '0;
            proc_bus_parity_pins_oe_o <= 1'b0;
            arbiter_pins_o <= '0;
            arbiter_pins_oe_o <= 1'b0;
        end
        else
        begin
            sdram_address_pins_o <= active
                ? addr[rfc_pkg::SDA_W-1:0] : '0;
            if (state == rfc_pkg::RFC_ADDR && mux_extra)
            begin
                rom_dedicated_data_port_oe_o <= 1'b1;
                rom_dedicated_data_port_o <= (phase == 2'h0) ? addr[31:24]
                    : (phase == 2'h1) ? addr[23:16] : addr[15:8];
            end
            else if (active && !cur_port)
            begin
                rom_dedicated_data_port_oe_o <= write;
                rom_dedicated_data_port_o <= write ? wbuf[7:0]
                    : addr[7:0];
            end
            else if (active && addr_mux_mode_i == rfc_pkg::MUX_HI)
            begin
                // board latches these on rising edge
                rom_dedicated_data_port_oe_o <= 1'b1;
                rom_dedicated_data_port_o <= addr[23:16];
            end
            else
            begin
                rom_dedicated_data_port_oe_o <= 1'b0;
                rom_dedicated_data_port_o <= '0;
            end
            sdram_data_oe_o <= active && cur_port && write;
            sdram_data_o <= wbuf;
            proc_bus_parity_pins_oe_o <= !bus_parity_enable_i
                && !parity_gpio_enable_i;
            arbiter_pins_oe_o <= !external_master_enable_i;
            if (addr_mux_mode_i[1])
            begin
                proc_bus_parity_pins_o <= addr[rfc_pkg::EXTRA_LO_C +: 6];
                arbiter_pins_o <= addr[rfc_pkg::EXTRA_LO_C +: 6];
            end
            else if (cur_port)
            begin
                proc_bus_parity_pins_o <= addr[rfc_pkg::EXTRA_LO_B +: 6];
                arbiter_pins_o <= addr[rfc_pkg::EXTRA_LO_B +: 6];
            end
            else
            begin
                proc_bus_parity_pins_o <= addr[rfc_pkg::EXTRA_LO_A +: 6];
                arbiter_pins_o <= addr[rfc_pkg::EXTRA_LO_A +: 6];
            end
        end
    end
endmodule

//--- rtl/rfc_pkg.sv
// constants for the rom flash bank controller
//
// Behaviour
// - accept all bus transactions to rom banks; buffer read data before returning
// - with retry enabled, retry master until the read response is returned
// - writes are posted into a buffer, releasing the bus early
// - sdram open during rom writes; closed during reads without retry
// - read cycle drives address, output enable and bank select
// - read_not_write high on reads; write enable low on writes
// - first wait count is cycles from select to data capture
// - recovery count is cycles from data to next address
// - each bank's first wait from its control; same for reads, writes
// - one shared state machine drives the bank select of the decoded bank
// - device ready input decides when read data is valid, only for banks with their ready-use bit set
// - transceiver select asserted for whole memory cycle
// - port bit 1 uses sdram data bus, 0 dedicated byte port
// - mux mode 11 shows all three address parts on byte port when it is also the data port (port bit 0)
// - parity and gpio both disabled frees parity pins for upper address
// - external master disabled frees arbiter pins for upper address
// - sdram side select enables external buffer during rom cycles of port bit 1 banks
// - low address bits shared onto sdram address and bank pins
// - upper address on parity pins only with parity and gpio disabled
// - upper address on arbiter pins when arbiter disabled
// - on shared byte port, address only at cycle start
package rfc_pkg;
    localparam int NBANK = 4;
    localparam int AW = 32;
    localparam int DW = 64;
    localparam int WAITW = 4;
    localparam logic [1:0] MUX_FULL = 2'h3;
    localparam logic [1:0] MUX_HI = 2'h2;
    localparam int ADDR_PHASES = 3;
    localparam int EXTRA_LO_A = 15;
    localparam int EXTRA_LO_B = 23;
    localparam int EXTRA_LO_C = 24;
    localparam int SDA_W = 15;
    typedef enum logic [5:0] {
        RFC_IDLE = 6'h01,
        RFC_ADDR = 6'h02,
        RFC_WAIT = 6'h04,
        RFC_DONE = 6'h08,
        RFC_RECV = 6'h10,
        RFC_RESP = 6'h20
    } rfc_state_e;
endpackage

//--- verification/rfc_controller_chk.sv
// assertion checker for the rom bank controller
`timescale 1ns/1ps
module rfc_controller_chk #(
    parameter int NBANK = 4
) (
    input wire logic sys_clk_i, reset_i, req_valid_i, req_write_i,
    input wire logic req_ready_o, req_retry_o, rsp_valid_o,
    input wire logic sdram_access_allow_o, retry_on_rom_read_enable_i,
    input wire logic [NBANK-1:0] rom_bank_select_n_o,
    input wire logic rom_output_enable_n_o, rom_write_enable_n_o,
    input wire logic rom_read_not_write_o, rom_transceiver_select_n_o
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_rd_take;
        req_valid_i && req_ready_o && !req_write_i;
    endsequence
    a_one_bank: assert property (
        $countones(~rom_bank_select_n_o) <= 1) else $error("two banks");
    a_we_not_rd: assert property (!rom_write_enable_n_o |->
        !rom_read_not_write_o && rom_output_enable_n_o) else $error("we");
    a_oe_is_rd: assert property (!rom_output_enable_n_o |->
        rom_read_not_write_o) else $error("oe without read");
    a_xcvr_whole: assert property (rom_bank_select_n_o != '1 |->
        !rom_transceiver_select_n_o) else $error("xcvr off");
    a_xcvr_soon: assert property (s_rd_take |->
        ##[1:3] !rom_transceiver_select_n_o) else $error("xcvr late");
    a_ready_valid: assert property (req_ready_o |-> req_valid_i)
        else $error("ready without request");
    a_retry_en: assert property (req_retry_o |->
        retry_on_rom_read_enable_i) else $error("retry while off");
    a_sdram_open: assert property (!sdram_access_allow_o |->
        !retry_on_rom_read_enable_i) else $error("sdram closed");
    a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response too long");
    a_rsp_idle: assert property (rsp_valid_o |->
        rom_bank_select_n_o == '1 && rom_output_enable_n_o)
        else $error("strobes held");
endmodule

bind rfc_controller rfc_controller_chk #(.NBANK(NBANK)) i_chk (.*);

//--- verification/rfc_rom_model.sv
// behavioural rom device on the far side of the bank pins
`timescale 1ns/1ps
module rfc_rom_model #(
    parameter int RDY_DLY = 3
) (
    input wire logic clk_i,
    input wire logic [3:0] sel_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [63:0] wd_i,
    output logic [63:0] rd_o,
    output logic ready_o,
    output logic [63:0] wr_o,
    input wire logic [7:0] ad_i,
    input wire logic ad_oe_i,
    output logic [23:0] hi_o
);
    logic [63:0] last = '0;
    logic [63:0] val;
    int cnt = 0;
    always_comb
    begin
        val = 64'hC3A5_0F1E_7D96_4B00;
        for (int i = 0; i < 4; i++)
            if (!sel_n_i[i])
                val[7:0] = 8'h10 + 8'(i);
    end
    // released bus shows no stale copy: inverse of the last value
    assign rd_o = (!oe_n_i && sel_n_i != 4'hF) ? val : ~last;
    assign ready_o = cnt >= RDY_DLY;
    always_ff @(posedge clk_i)
    begin
        last <= rd_o;
        cnt <= (!oe_n_i && sel_n_i != 4'hF) ? cnt + 1 : 0;
        if (!we_n_i && sel_n_i != 4'hF)
            wr_o <= wd_i;
        // board latch: rising-edge capture of address bytes
        if (ad_oe_i)
            hi_o <= {hi_o[15:0], ad_i};
    end
endmodule

//--- verification/rfc_controller_tb.sv
// self-checking bench for the rom bank controller
`timescale 1ns/1ps
module rfc_controller_tb;
    logic sys_clk_i = 0;
    logic reset_i = 1;
    logic req_valid_i = 0;
    logic req_write_i = 0;
    logic retry_on_rom_read_enable_i = 0;
    logic [31:0] req_addr_i = '0;
    logic [63:0] req_wdata_i = '0;
    logic [127:0] bank_base_i = 128'h3000_0000_2000_0000_1000_0000_0000_0000;
    logic [127:0] bank_mask_i = {4{32'hF000_0000}};
    logic [15:0] first_wait_count_i = 16'h4321;
    logic [15:0] recovery_count_i = 16'h2222;
    logic [3:0] bank_port_select_i = 4'hF;
    logic [3:0] bank_ready_use_i = 4'h0;
    logic [1:0] addr_mux_mode_i = 2'h0;
    logic bus_parity_enable_i = 0;
    logic parity_gpio_enable_i = 0;
    logic external_master_enable_i = 0;
    logic rom_device_ready_in_i;
    logic [63:0] sdram_data_i, sdram_data_o, rsp_rdata_o, wr_seen;
    logic [23:0] hi_seen;
    logic [7:0] rom_dedicated_data_port_i, rom_dedicated_data_port_o;
    logic [14:0] sdram_address_pins_o;
    logic [5:0] proc_bus_parity_pins_o, arbiter_pins_o;
    logic [3:0] rom_bank_select_n_o;
    logic req_ready_o, req_retry_o, rsp_valid_o, sdram_access_allow_o;
    logic sdram_data_oe_o, rom_dedicated_data_port_oe_o;
    logic proc_bus_parity_pins_oe_o, arbiter_pins_oe_o;
    logic rom_output_enable_n_o, rom_write_enable_n_o, rom_read_not_write_o;
    logic rom_transceiver_select_n_o, sdram_side_buffer_select_o;
    int n_fail = 0;
    int num_checks = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    rfc_controller i_dut (.*);
    rfc_rom_model #(.RDY_DLY(6)) i_rom (
        .clk_i(sys_clk_i),
        .sel_n_i(rom_bank_select_n_o),
        .oe_n_i(rom_output_enable_n_o),
        .we_n_i(rom_write_enable_n_o),
        .wd_i(sdram_data_o),
        .rd_o(sdram_data_i),
        .ready_o(rom_device_ready_in_i),
        .wr_o(wr_seen),
        .ad_i(rom_dedicated_data_port_o),
        .ad_oe_i(rom_dedicated_data_port_oe_o),
        .hi_o(hi_seen)
    );
    assign rom_dedicated_data_port_i = sdram_data_i[7:0];
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input bit c, input string m);
        num_checks++;
        if (!c)
        begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic take(input logic w, input logic [31:0] a, logic [63:0] d);
        int n = 0;
        @(posedge sys_clk_i);
        req_valid_i <= 1;
        req_write_i <= w;
        req_addr_i <= a;
        req_wdata_i <= d;
        do
            @(negedge sys_clk_i);
        while (req_ready_o !== 1'b1 && ++n < 200);
        @(posedge sys_clk_i);
        req_valid_i <= 0;
    endtask
    task automatic rd(input logic [31:0] a, logic [63:0] m, int lat, bit ex);
        int n = 0;
        int nr = 0;
        int na = 0;
        logic [7:0] q[$];
        logic [1:0] b;
        logic [5:0] xa;
        b = a[29:28];
        xa = addr_mux_mode_i[1] ? a[29:24] :
            bank_port_select_i[b] ? a[28:23] : a[20:15];
        take(0, a, '0);
        if (retry_on_rom_read_enable_i)
        begin
            // a retried master keeps presenting the same read
            @(posedge sys_clk_i);
            req_valid_i <= 1;
            n = 1;
        end
        while (rsp_valid_o !== 1'b1 && n < 300)
        begin
            @(negedge sys_clk_i);
            n++;
            nr += req_retry_o === 1'b1;
            na += sdram_access_allow_o === 1'b0;
            if (rom_dedicated_data_port_oe_o === 1'b1)
                q.push_back(rom_dedicated_data_port_o);
            if (rom_bank_select_n_o !== 4'hF)
            begin
                chk(rom_bank_select_n_o === ~(4'h1 << b), "bank");
                chk(rom_read_not_write_o === 1'b1, "rnw");
                chk(rom_output_enable_n_o === 1'b0 &&
                    rom_transceiver_select_n_o === 1'b0, "oe");
                chk(sdram_side_buffer_select_o ===
                    bank_port_select_i[b], "sdsel");
                chk(proc_bus_parity_pins_oe_o === !bus_parity_enable_i &&
                    (bus_parity_enable_i || proc_bus_parity_pins_o === xa), "par");
                chk(arbiter_pins_oe_o === !external_master_enable_i &&
                    (external_master_enable_i || arbiter_pins_o === xa), "arb");
                if (addr_mux_mode_i == 2'h0)
                    chk(sdram_address_pins_o === a[14:0], "sda");
            end
        end
        if (retry_on_rom_read_enable_i)
        begin
            @(posedge sys_clk_i);
            req_valid_i <= 0;
        end
        chk(n == lat || (!ex && n > lat && n < 300), "time");
        chk((rsp_rdata_o & m) === ((64'hC3A5_0F1E_7D96_4B10 + b) & m), "data");
        chk(retry_on_rom_read_enable_i ? nr > 0 && na == 0 :
            nr == 0 && na > 0, "retry");
        if (addr_mux_mode_i == 2'h3 && !bank_port_select_i[b])
        begin
            chk(q.size() == 3 && {q[0], q[1], q[2]} === a[31:8], "mux");
            chk(hi_seen === a[31:8], "latch");
        end
    endtask
    task automatic wt(input logic [31:0] a, input logic [63:0] d);
        int n = 0;
        int na = 0;
        take(1, a, d);
        while (rom_write_enable_n_o !== 1'b0 && n < 100)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(n > 0 && rom_read_not_write_o === 1'b0, "we");
        chk(sdram_data_oe_o === 1'b1 && sdram_data_o === d, "wdata");
        while (rom_bank_select_n_o !== 4'hF && n < 100)
        begin
            @(negedge sys_clk_i);
            n++;
            na += sdram_access_allow_o === 1'b0;
        end
        chk(wr_seen === d && na == 0 && rsp_valid_o !== 1'b1, "post");
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 0;
        for (int i = 0; i < 4; i++)
            rd(32'h05A3_C6E8 | (i << 28), '1, 8 + i, 1);
        @(posedge sys_clk_i);
        retry_on_rom_read_enable_i <= 1;
        rd(32'h15A3_C6E8, '1, 9, 1);
        wt(32'h1123_4568, 64'h0F1E_2D3C_4B5A_6978);
        @(posedge sys_clk_i);
        retry_on_rom_read_enable_i <= 0;
        addr_mux_mode_i <= 2'h3;
        bank_port_select_i <= 4'hE;
        bus_parity_enable_i <= 1;
        external_master_enable_i <= 1;
        rd(32'h0876_5438, 64'hFF, 10, 1);
        @(posedge sys_clk_i);
        addr_mux_mode_i <= 2'h0;
        bank_ready_use_i <= 4'h4;
        // slow device: ready comes later than the first wait
        rd(32'h2222_2220, '1, 14, 1);
        summarize();
    end
    // tests need well under 1000 cycles; 20000 leaves ample margin
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end
endmodule
